// *** serial_mode_ctrl.sv ***
`timescale 1ns/1ns
// Contract
// - CTS change flag raises the interrupt when the CTS interrupt enable is set.
// - CTS flow enable makes transmission wait on the clear-to-send input.
// - RTS flow enable drives request-to-send from receiver readiness.
// - Transmit DMA enable issues DMA requests for transmit data.
// - Receive DMA enable issues DMA requests for received data.
// - Smartcard enable places the transceiver in smartcard mode.
// - In smartcard mode with PARITY_ERROR_NEGATIVE_ACK_ENABLE enabled, parity errors send a PARITY_ERROR_NEGATIVE_ACK_ENABLE.
// - Half-duplex select switches to single-line half-duplex operation.
// - Infrared low-power bit selects low-power encoding when infrared is on.
// - Infrared enable turns on infrared encoding and decoding.
// - Error interrupt enable plus receive DMA raises interrupt on framing, overrun, noise.
// - Smartcard mode delays transmission complete by guard time in baud clocks.
// - Low-power infrared divides source clock by full prescaler; zero holds.
// - Smartcard clock is source divided by twice lower five prescaler bits.
module serial_mode_ctrl #(
  parameter int addr_width = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transceiver core events, same clock
  input wire logic baud_tick,
  input wire logic tx_shift_done,
  input wire logic rx_parity_error,
  input wire logic framing_error_flag,
  input wire logic overrun_error_flag,
  input wire logic noise_error_flag,
  input wire logic rx_ready,
  input wire logic tx_data_empty,
  input wire logic rx_data_full,
  // Flow control pins
  input wire logic cts_n,
  output logic rts_n,
  output logic tx_permit,
  // DMA requests
  output logic tx_dma_req,
  output logic rx_dma_req,
  // Mode outputs to the transceiver core
  output logic smartcard_mode,
  output logic half_duplex,
  output logic infrared_mode,
  output logic infrared_low_power_mode,
  output logic parity_error_negative_ack_enable_send,
  output logic tx_complete,
  // Divided clocks
  output logic ir_lp_tick,
  output logic card_clk,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [serial_mode_pkg::ctrl3_width-1:0] ctrl;
    logic [serial_mode_pkg::guard_width-1:0] guard;
    logic [serial_mode_pkg::psc_width-1:0] clock_prescaler;
    logic [serial_mode_pkg::status_width-1:0] status;
    logic [serial_mode_pkg::status_width-1:0] mask;
    logic cts_s1;
    logic cts_s2;
    logic cts_s3;
    serial_mode_pkg::guard_state_e gstate;
    logic [serial_mode_pkg::guard_width-1:0] guard_cnt;
    logic [serial_mode_pkg::psc_width-1:0] div_cnt;
    logic card_clk;
    logic ir_tick;
    logic rts_n;
    logic tx_permit;
    logic tx_dma_req;
    logic rx_dma_req;
    logic parity_error_negative_ack_enable_send;
    logic irq;
    logic ir_lp_mode;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [serial_mode_pkg::ctrl3_width-1:0] c;
  logic setup;
  logic wr_access;
  logic [serial_mode_pkg::status_width-1:0] set_bits;
  logic [serial_mode_pkg::status_width-1:0] clr_bits;
  logic [serial_mode_pkg::status_width-1:0] irq_gate;
  logic [serial_mode_pkg::status_width-1:0] status_new;
  logic [serial_mode_pkg::psc_width-1:0] divisor;
  logic ir_lp_on;
  logic tc_set;

  assign c = state_reg.ctrl;

  always_comb begin
    state_next = state_reg;
    setup = psel && !penable;
    wr_access = psel && penable && pwrite && state_reg.pready;
    tc_set = 1'b0;
    clr_bits = '0;
    ir_lp_on = c[serial_mode_pkg::ir_en_bit] && c[serial_mode_pkg::ir_low_power_bit];

    // Answer one cycle after setup; the access phase completes in its first cycle
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.prdata = 32'h0000_0000;
    if (setup) begin
      state_next.pready = 1'b1;
      if (!pwrite) begin
        // Reserved bits are zero-extended on read
        case (paddr[7:0])
          serial_mode_pkg::ctrl3_offset: state_next.prdata = {21'h00_0000, c};
          serial_mode_pkg::gpr_offset: state_next.prdata = {16'h0000, state_reg.guard, state_reg.clock_prescaler};
          serial_mode_pkg::status_offset: state_next.prdata = {27'h000_0000, state_reg.status};
          serial_mode_pkg::mask_offset: state_next.prdata = {27'h000_0000, state_reg.mask};
          default: state_next.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr[7:0])
          serial_mode_pkg::ctrl3_offset,
          serial_mode_pkg::gpr_offset,
          serial_mode_pkg::status_offset,
          serial_mode_pkg::mask_offset: state_next.pslverr = 1'b0;
          default: state_next.pslverr = 1'b1;
        endcase
      end
    end

    // Register writes; only the defined bits are captured
    if (wr_access) begin
      case (paddr[7:0])
        serial_mode_pkg::ctrl3_offset: state_next.ctrl = pwdata[serial_mode_pkg::ctrl3_width-1:0];
        serial_mode_pkg::gpr_offset: begin
          state_next.guard = pwdata[serial_mode_pkg::guard_lsb +: serial_mode_pkg::guard_width];
          state_next.clock_prescaler = pwdata[serial_mode_pkg::psc_lsb +: serial_mode_pkg::psc_width];
        end
        serial_mode_pkg::status_offset: clr_bits = pwdata[serial_mode_pkg::status_width-1:0];
        serial_mode_pkg::mask_offset: state_next.mask = pwdata[serial_mode_pkg::status_width-1:0];
        default: state_next.mask = state_reg.mask;
      endcase
    end

    // Clear-to-send pin, two flops before use; third flop only for change detection
    state_next.cts_s1 = cts_n;
    state_next.cts_s2 = state_reg.cts_s1;
    state_next.cts_s3 = state_reg.cts_s2;

    // With CTS flow enable set, transmit allowed only while the peer asserts clear-to-send
    state_next.tx_permit = !c[serial_mode_pkg::cts_flow_en_bit] || !state_reg.cts_s2;
    // Request-to-send asserted (low) while the receiver can take data
    state_next.rts_n = c[serial_mode_pkg::rts_flow_en_bit] && !rx_ready;
    state_next.tx_dma_req = c[serial_mode_pkg::tx_dma_en_bit] && tx_data_empty;
    state_next.rx_dma_req = c[serial_mode_pkg::rx_dma_en_bit] && rx_data_full;
    state_next.parity_error_negative_ack_enable_send = c[serial_mode_pkg::smartcard_en_bit] && c[serial_mode_pkg::parity_error_negative_ack_enable_en_bit]
      && rx_parity_error;

    // Guard time delays transmission complete in smartcard mode
    case (state_reg.gstate)
      serial_mode_pkg::guard_idle: begin
        if (tx_shift_done) begin
          if (c[serial_mode_pkg::smartcard_en_bit] && state_reg.guard != 8'h00) begin
            state_next.gstate = serial_mode_pkg::guard_wait;
            state_next.guard_cnt = state_reg.guard;
          end else begin
            tc_set = 1'b1;
          end
        end
      end
      serial_mode_pkg::guard_wait: begin
        if (baud_tick) begin
          state_next.guard_cnt = state_reg.guard_cnt - 8'h01;
          if (state_reg.guard_cnt == 8'h01) begin
            state_next.gstate = serial_mode_pkg::guard_idle;
            tc_set = 1'b1;
          end
        end
      end
      default: state_next.gstate = serial_mode_pkg::guard_idle;
    endcase

    // Prescaler: full value for low-power infrared, low five bits for the card clock
    if (c[serial_mode_pkg::smartcard_en_bit]) begin
      divisor = {3'h0, state_reg.clock_prescaler[serial_mode_pkg::card_psc_width-1:0]};
    end else if (ir_lp_on) begin
      divisor = state_reg.clock_prescaler;
    end else begin
      divisor = 8'h00;
    end
    state_next.ir_tick = 1'b0;
    if (divisor == 8'h00) begin
      // Zero holds the divided clock where it stands
      state_next.div_cnt = 8'h00;
    end else if (state_reg.div_cnt >= divisor - 8'h01) begin
      state_next.div_cnt = 8'h00;
      state_next.ir_tick = ir_lp_on && !c[serial_mode_pkg::smartcard_en_bit];
      if (c[serial_mode_pkg::smartcard_en_bit]) begin
        // Toggle every divisor cycles gives a period of twice the divisor
        state_next.card_clk = !state_reg.card_clk;
      end
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 8'h01;
    end

    // Sticky status; a set in the same cycle as its clear wins
    set_bits = '0;
    set_bits[serial_mode_pkg::st_cts_change_bit] = state_reg.cts_s2 != state_reg.cts_s3;
    set_bits[serial_mode_pkg::st_framing_bit] = framing_error_flag;
    set_bits[serial_mode_pkg::st_overrun_bit] = overrun_error_flag;
    set_bits[serial_mode_pkg::st_noise_bit] = noise_error_flag;
    set_bits[serial_mode_pkg::st_tx_complete_bit] = tc_set;
    status_new = (state_reg.status & ~clr_bits) | set_bits;
    state_next.status = status_new;

    // Each source but transmit complete is gated by its control enable; all are gated by the mask
    irq_gate = '0;
    irq_gate[serial_mode_pkg::st_cts_change_bit] = c[serial_mode_pkg::cts_irq_en_bit];
    irq_gate[serial_mode_pkg::st_framing_bit] = c[serial_mode_pkg::err_irq_en_bit]
      && c[serial_mode_pkg::rx_dma_en_bit];
    irq_gate[serial_mode_pkg::st_overrun_bit] = irq_gate[serial_mode_pkg::st_framing_bit];
    irq_gate[serial_mode_pkg::st_noise_bit] = irq_gate[serial_mode_pkg::st_framing_bit];
    irq_gate[serial_mode_pkg::st_tx_complete_bit] = 1'b1;
    state_next.irq = |(status_new & state_next.mask & irq_gate);
    // Taken from the next control value so the flopped output tracks the register bits
    state_next.ir_lp_mode = state_next.ctrl[serial_mode_pkg::ir_en_bit]
      && state_next.ctrl[serial_mode_pkg::ir_low_power_bit];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.ctrl <= serial_mode_pkg::ctrl3_reset;
      state_reg.guard <= serial_mode_pkg::guard_reset;
      state_reg.clock_prescaler <= serial_mode_pkg::psc_reset;
      state_reg.status <= serial_mode_pkg::status_reset;
      state_reg.mask <= serial_mode_pkg::mask_reset;
      state_reg.cts_s1 <= 1'b1;
      state_reg.cts_s2 <= 1'b1;
      state_reg.cts_s3 <= 1'b1;
      state_reg.gstate <= serial_mode_pkg::guard_idle;
      state_reg.tx_permit <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign rts_n = state_reg.rts_n;
  assign tx_permit = state_reg.tx_permit;
  assign tx_dma_req = state_reg.tx_dma_req;
  assign rx_dma_req = state_reg.rx_dma_req;
  assign smartcard_mode = c[serial_mode_pkg::smartcard_en_bit];
  assign half_duplex = c[serial_mode_pkg::half_duplex_bit];
  assign infrared_mode = c[serial_mode_pkg::ir_en_bit];
  assign infrared_low_power_mode = state_reg.ir_lp_mode;
  assign parity_error_negative_ack_enable_send = state_reg.parity_error_negative_ack_enable_send;
  assign tx_complete = state_reg.status[serial_mode_pkg::st_tx_complete_bit];
  assign ir_lp_tick = state_reg.ir_tick;
  assign card_clk = state_reg.card_clk;
  assign irq = state_reg.irq;

endmodule

// *** serial_mode_ctrl_tb.sv ***
`timescale 1ns/1ns
module serial_mode_ctrl_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, v;
  logic pready, pslverr, baud_tick = 1'h0, tx_shift_done = 1'h0, rx_parity_error = 1'h0;
  logic framing_error_flag = 1'h0, overrun_error_flag = 1'h0, noise_error_flag = 1'h0;
  logic tx_data_empty = 1'h0, rx_data_full = 1'h0, peer_busy = 1'h0, peer_full = 1'h0;
  logic cts_n, rx_ready, rts_n, tx_permit, tx_dma_req, rx_dma_req, smartcard_mode, half_duplex;
  logic infrared_mode, infrared_low_power_mode, parity_error_negative_ack_enable_send, tx_complete, ir_lp_tick, card_clk, irq, pc;
  logic [32:0] q[$];
  logic [31:0] mode_tab[6] = '{32'h0000_0020, 32'h0000_0020, 32'h0000_0020, 32'h0000_0006, 32'h0000_0006, 32'h0000_0002};
  logic [31:0] psc_tab[6] = '{32'h0000_0003, 32'h0000_0023, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000, 32'h0000_0001};
  int exp_tab[6] = '{20, 20, 0, 12, 0, 0};
  int err_count = 0, checks = 0, c;
  serial_mode_ctrl uut (.*);
  serial_peer_model peer (.*);
  always #2 pclk = ~pclk;
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, {1'h0, e});
  endtask
  always @(posedge pclk) if (pready === 1'h1 && pwrite === 1'h0) chk({pslverr, prdata}, q.pop_front());
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'he3a7_ffc7));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    chk(33'({rts_n, tx_permit}), 33'h1);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0000_07ff);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0000_ffff);
    apb(1'h0, 8'h40, 32'h0, 33'h1_0000_0000);
    for (int i = 0; i < 11; i++) begin
      v = ($urandom & 32'h0000_07ff) | (32'h1 << i);
      wr(8'h14, v);
      chk(33'({smartcard_mode, half_duplex, infrared_mode, infrared_low_power_mode}), 33'({v[5], v[3], v[1], v[1] & v[2]}));
    end
    wr(8'h1c, 32'h0000_001f);
    wr(8'h20, 32'h0000_001f);
    wr(8'h14, 32'h0000_0700);
    @(posedge pclk) begin peer_full <= 1'h1; peer_busy <= 1'h1; end
    repeat (8) @(negedge pclk);
    chk(33'({rts_n, tx_permit, irq}), 33'h5);
    wr(8'h1c, 32'h0000_0001);
    wr(8'h14, 32'h0000_0300);
    @(posedge pclk) peer_busy <= 1'h0;
    repeat (8) @(negedge pclk);
    chk(33'({tx_permit, irq}), 33'h2);
    rd(8'h1c, 32'h0000_0001);
    wr(8'h1c, 32'h0000_001f);
    wr(8'h14, 32'h0000_00c1);
    @(posedge pclk) begin tx_data_empty <= 1'h1; rx_data_full <= 1'h1; framing_error_flag <= 1'h1; end
    @(posedge pclk) framing_error_flag <= 1'h0;
    @(negedge pclk);
    chk(33'({tx_dma_req, rx_dma_req, irq}), 33'h7);
    wr(8'h1c, 32'h0000_001f);
    wr(8'h14, 32'h0000_0001);
    @(posedge pclk) begin overrun_error_flag <= 1'h1; noise_error_flag <= 1'h1; end
    @(posedge pclk) begin overrun_error_flag <= 1'h0; noise_error_flag <= 1'h0; end
    @(negedge pclk);
    chk(33'({tx_dma_req, rx_dma_req, irq}), 33'h0);
    rd(8'h1c, 32'h0000_000c);
    wr(8'h14, 32'h0000_0030);
    @(posedge pclk) rx_parity_error <= 1'h1;
    @(posedge pclk) rx_parity_error <= 1'h0;
    @(negedge pclk);
    chk(33'(parity_error_negative_ack_enable_send), 33'h1);
    wr(8'h18, 32'h0000_0300);
    wr(8'h14, 32'h0000_0020);
    wr(8'h1c, 32'h0000_001f);
    @(posedge pclk) tx_shift_done <= 1'h1;
    @(posedge pclk) tx_shift_done <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      @(negedge pclk);
      chk(33'(tx_complete), 33'h0);
      @(posedge pclk) baud_tick <= 1'h1;
      @(posedge pclk) baud_tick <= 1'h0;
    end
    @(negedge pclk);
    chk(33'(tx_complete), 33'h1);
    for (int k = 0; k < 6; k++) begin
      wr(8'h14, mode_tab[k]);
      wr(8'h18, psc_tab[k]);
      repeat (12) @(negedge pclk);
      c = 0;
      pc = card_clk;
      repeat (60) begin
        @(negedge pclk);
        c += int'(card_clk !== pc) + int'(ir_lp_tick);
        pc = card_clk;
      end
      chk(33'(c), 33'(exp_tab[k]));
    end
    final_report();
  end
endmodule
bind serial_mode_ctrl serial_mode_props #(.addr_width(addr_width)) props (.*);

// *** serial_mode_pkg.sv ***
package serial_mode_pkg;

  // Byte offsets on the register bus
  localparam logic [7:0] ctrl3_offset = 8'h14;
  localparam logic [7:0] gpr_offset = 8'h18;
  localparam logic [7:0] status_offset = 8'h1c;
  localparam logic [7:0] mask_offset = 8'h20;

  // Control register three, field positions
  localparam int ctrl3_width = 11;
  localparam int cts_irq_en_bit = 10;
  localparam int cts_flow_en_bit = 9;
  localparam int rts_flow_en_bit = 8;
  localparam int tx_dma_en_bit = 7;
  localparam int rx_dma_en_bit = 6;
  localparam int smartcard_en_bit = 5;
  localparam int parity_error_negative_ack_enable_en_bit = 4;
  localparam int half_duplex_bit = 3;
  localparam int ir_low_power_bit = 2;
  localparam int ir_en_bit = 1;
  localparam int err_irq_en_bit = 0;

  // Guard time and prescaler fields
  localparam int guard_lsb = 8;
  localparam int guard_width = 8;
  localparam int psc_lsb = 0;
  localparam int psc_width = 8;
  localparam int card_psc_width = 5;

  // Status and mask layout
  localparam int status_width = 5;
  localparam int st_cts_change_bit = 0;
  localparam int st_framing_bit = 1;
  localparam int st_overrun_bit = 2;
  localparam int st_noise_bit = 3;
  localparam int st_tx_complete_bit = 4;

  // Values after reset
  localparam logic [ctrl3_width-1:0] ctrl3_reset = 11'h000;
  localparam logic [guard_width-1:0] guard_reset = 8'h00;
  localparam logic [psc_width-1:0] psc_reset = 8'h00;
  localparam logic [status_width-1:0] status_reset = 5'h00;
  localparam logic [status_width-1:0] mask_reset = 5'h00;

  typedef enum logic {
    guard_idle = 1'b0,
    guard_wait = 1'b1
  } guard_state_e;

endpackage

// *** serial_mode_props.sv ***
`timescale 1ns/1ns
module serial_mode_props #(
  parameter int addr_width = 8
) (
  // Bus
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Core and pins
  input wire logic baud_tick, tx_shift_done, rx_parity_error, rx_ready,
  input wire logic tx_data_empty, rx_data_full, cts_n, rts_n, tx_permit,
  input wire logic tx_dma_req, rx_dma_req, smartcard_mode, parity_error_negative_ack_enable_send,
  input wire logic infrared_mode, infrared_low_power_mode,
  input wire logic tx_complete, ir_lp_tick, card_clk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr3;
  assign wr3 = psel && penable && pready && pwrite && paddr == serial_mode_pkg::ctrl3_offset;
  property p_rts; rts_n |-> !$past(rx_ready); endproperty
  a_rts: assert property (p_rts) else $error("rts without full receiver");
  // The pin passes two sync flops, so either latency is accepted
  property p_cts; !tx_permit |-> $past(cts_n, 2) || $past(cts_n, 3); endproperty
  a_cts: assert property (p_cts) else $error("transmit held without cts");
  property p_txdma; tx_dma_req |-> $past(tx_data_empty); endproperty
  a_txdma: assert property (p_txdma) else $error("tx dma request without empty");
  property p_rxdma; rx_dma_req |-> $past(rx_data_full); endproperty
  a_rxdma: assert property (p_rxdma) else $error("rx dma request without data");
  property p_parity_error_negative_ack_enable; parity_error_negative_ack_enable_send |-> $past(rx_parity_error && smartcard_mode); endproperty
  a_parity_error_negative_ack_enable: assert property (p_parity_error_negative_ack_enable) else $error("parity_error_negative_ack_enable without parity error");
  property p_mode; $rose(smartcard_mode) |-> $past(wr3 && pwdata[5]); endproperty
  a_mode: assert property (p_mode) else $error("smartcard mode without write");
  property p_infrared_low_power; infrared_low_power_mode |-> infrared_mode; endproperty
  a_infrared_low_power: assert property (p_infrared_low_power) else $error("low power without infrared");
  property p_irtick; ir_lp_tick |-> $past(infrared_low_power_mode && !smartcard_mode); endproperty
  a_irtick: assert property (p_irtick) else $error("infrared tick outside mode");
  property p_card; $rose(card_clk) |-> $past(smartcard_mode); endproperty
  a_card: assert property (p_card) else $error("card clock outside smartcard");
  property p_resv; pready && !pwrite && paddr == 8'h14 |-> prdata[31:11] == 21'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_tc; $rose(tx_complete) |-> $past(tx_shift_done || baud_tick); endproperty
  a_tc: assert property (p_tc) else $error("transmit complete without cause");
  c_parity_error_negative_ack_enable: cover property (parity_error_negative_ack_enable_send);
  c_guard: cover property ($rose(tx_complete) && smartcard_mode);
  c_tick: cover property (ir_lp_tick);
endmodule

// *** serial_peer_model.sv ***
`timescale 1ns/1ns
module serial_peer_model (
  // Clock
  input wire logic pclk,
  // What the peer wants
  input wire logic peer_busy,
  input wire logic peer_full,
  // Lines toward the port
  output logic cts_n,
  output logic rx_ready
);
  // Reacts one edge late, like a slow peer
  always_ff @(posedge pclk) begin
    cts_n <= peer_busy;
    rx_ready <= !peer_full;
  end
endmodule
